// File: rtl/reset_state_controller.v
`timescale 1ns/100ps
`include "reset_state_map.vh"
// Operation
// RQ1: Watchdog expiry while running resets the core and sets expiry flag.
// RQ2: Watchdog expiry while halted is warm: only PC, SP, flag change.
// RQ3: Power-on clears both flags; supply-drop reset keeps both flags.
// RQ4: Running watchdog reset sets expiry flag, keeps power-down flag.
// RQ5: Halted watchdog reset sets both flags to one.
// RQ6: Pin reset running keeps flags; pin reset halted gives 0 and 1.
// RQ7: All resets disable interrupts except warm reset, which keeps them.
// RQ8: Watchdog counter is cleared at reset and restarts at once.
// RQ9: Non-warm resets switch timers off, controls loaded with zeros.
// RQ10: Non-warm resets make ports inputs: direction, data ones; pulls zero.
// RQ11: After reset stack pointer is top, PC and its low byte are zero.
// RQ12: Cold resets load watchdog, pin-select defaults; only POR drops acc.
// RQ13: Warm reset retains all other register contents.
// RQ14: Pin-select values gpio or reset pin; others reset after debounce.
// RQ15: Supply-drop reset sets its cause flag; software only clears it.
// RQ16: Core held in reset until start-up delay ends, then fetches zero.
// RQ17: Power-on reset wins over all other simultaneous sources.
module reset_state_controller #(
  parameter STARTUP = `STARTUP_CYCLES
) (
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        rst_in,
  // Reset sources
  input  wire        power_on_in,
  input  wire        supply_drop_reset_in,
  input  wire        ext_reset_pin_n_in,
  input  wire        watchdog_expire_in,
  input  wire        halted_in,
  input  wire        slow_tick_in,
  // Software access
  input  wire        pin_sel_wr_in,
  input  wire [7:0]  pin_sel_data_in,
  input  wire        sd_flag_clr_in,
  // Core state
  output reg         core_reset_out,
  output reg         warm_out,
  output reg         cold_load_out,
  output reg         por_load_out,
  output reg         wdt_expiry_flag_out,
  output reg         powerdown_flag_out,
  output reg         supply_drop_cause_flag_out,
  output reg         watchdog_timer_clear_out,
  output reg  [11:0] pc_out,
  output reg  [7:0]  pcl_out,
  output reg  [3:0]  sp_out,
  output reg  [7:0]  intc_out,
  output reg  [7:0]  timer_ctrl_out,
  output reg  [7:0]  port_a_direction_out,
  output reg  [7:0]  port_data_out,
  output reg  [7:0]  port_pull_out,
  output reg  [7:0]  port_wake_out,
  output reg  [7:0]  watchdog_control_out,
  output reg  [7:0]  pin_reset_select_out
);
  // ****************************************************************
  // Source decode
  // ****************************************************************
  reg  [7:0]  pin_sel;
  reg  [15:0] delay;
  reg  [2:0]  cause;
  reg         pending;
  wire        sel_bad;
  wire        sel_fire;
  wire        pin_active;
  wire        any_src;

  function sel_legal;
    input [7:0] v;
    begin
      sel_legal = (v == `PIN_SEL_GPIO) || (v == `PIN_SEL_RESET);
    end
  endfunction

  assign sel_bad    = !sel_legal(pin_sel); // RQ14
  assign pin_active = !ext_reset_pin_n_in && (pin_sel == `PIN_SEL_RESET);
  assign any_src    = power_on_in || supply_drop_reset_in || pin_active ||
                      watchdog_expire_in || sel_fire;

  slow_debounce #(
    .TICKS(`DEBOUNCE_SLOW_CLOCKS)
  ) u_debounce (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .slow_tick_in(slow_tick_in),
    .cond_in     (sel_bad),
    .fire_out    (sel_fire)
  );

  // Priority order fixes which flags a mixed event produces.
  reg [2:0] next_cause;
  always @* begin
    next_cause = `CAUSE_SEL;
    if (power_on_in) begin
      next_cause = `CAUSE_POR; // RQ17
    end else if (supply_drop_reset_in) begin
      next_cause = `CAUSE_LVR;
    end else if (pin_active) begin
      next_cause = halted_in ? `CAUSE_PIN_HALT : `CAUSE_PIN_RUN;
    end else if (watchdog_expire_in) begin
      next_cause = halted_in ? `CAUSE_WDT_HALT : `CAUSE_WDT_RUN;
    end
  end

  // ****************************************************************
  // Sequencing and state loading
  // ****************************************************************
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      cause                      <= `CAUSE_POR;
      pending                    <= 1'b1;
      delay                      <= 16'h0000;
      core_reset_out             <= 1'b1;
      warm_out                   <= 1'b0;
      cold_load_out              <= 1'b1;
      por_load_out               <= 1'b1;
      wdt_expiry_flag_out        <= 1'b0;
      powerdown_flag_out         <= 1'b0;
      supply_drop_cause_flag_out <= 1'b0;
      watchdog_timer_clear_out   <= 1'b1;
      pc_out                     <= `PC_RESET;
      pcl_out                    <= `PCL_RESET;
      sp_out                     <= `SP_TOP;
      intc_out                   <= `INTC_DEFAULT;
      timer_ctrl_out             <= `TIMER_CTRL_DEFAULT;
      port_a_direction_out       <= `PORT_DIR_DEFAULT;
      port_data_out              <= `PORT_DATA_DEFAULT;
      port_pull_out              <= `PORT_PULL_DEFAULT;
      port_wake_out              <= `PORT_WAKE_DEFAULT;
      watchdog_control_out       <= `WDOG_CTRL_DEFAULT;
      pin_reset_select_out       <= `PIN_SEL_DEFAULT;
      pin_sel                    <= `PIN_SEL_DEFAULT;
    end else begin
      watchdog_timer_clear_out <= 1'b0;
      if (pin_sel_wr_in) begin
        pin_sel              <= pin_sel_data_in;
        pin_reset_select_out <= pin_sel_data_in;
      end
      // The set wins so a drop arriving during a clear is not lost.
      if (supply_drop_reset_in) begin
        supply_drop_cause_flag_out <= 1'b1; // RQ15
      end else if (sd_flag_clr_in) begin
        supply_drop_cause_flag_out <= 1'b0;
      end
      if (any_src) begin
        cause          <= next_cause;
        pending        <= 1'b1;
        delay          <= 16'h0000;
        core_reset_out <= 1'b1; // RQ1
        if (sel_fire) begin
          // The bad select drops at once, or the source would never fall.
          pin_sel <= `PIN_SEL_DEFAULT; // RQ14
        end
      end else if (pending) begin
        // The core is released only after the start-up count ends.
        if (delay == STARTUP[15:0] - 16'h0001) begin
          pending                  <= 1'b0;
          core_reset_out           <= 1'b0; // RQ16
          watchdog_timer_clear_out <= 1'b1; // RQ8
          warm_out                 <= (cause == `CAUSE_WDT_HALT); // RQ2
          cold_load_out            <= (cause != `CAUSE_WDT_HALT);
          por_load_out             <= (cause == `CAUSE_POR); // RQ12
          pc_out                   <= `PC_RESET; // RQ11
          pcl_out                  <= `PCL_RESET;
          sp_out                   <= `SP_TOP;
          case (cause)
            `CAUSE_POR: begin
              wdt_expiry_flag_out <= 1'b0; // RQ3
              powerdown_flag_out  <= 1'b0;
            end
            `CAUSE_WDT_RUN: begin
              wdt_expiry_flag_out <= 1'b1; // RQ4
            end
            `CAUSE_WDT_HALT: begin
              wdt_expiry_flag_out <= 1'b1; // RQ5
              powerdown_flag_out  <= 1'b1;
            end
            `CAUSE_PIN_HALT: begin
              wdt_expiry_flag_out <= 1'b0; // RQ6
              powerdown_flag_out  <= 1'b1;
            end
            default: begin
              wdt_expiry_flag_out <= wdt_expiry_flag_out;
            end
          endcase
          // Warm reset keeps everything below untouched.
          if (cause != `CAUSE_WDT_HALT) begin // RQ13
            intc_out             <= `INTC_DEFAULT; // RQ7
            timer_ctrl_out       <= `TIMER_CTRL_DEFAULT; // RQ9
            port_a_direction_out <= `PORT_DIR_DEFAULT; // RQ10
            port_data_out        <= `PORT_DATA_DEFAULT;
            port_pull_out        <= `PORT_PULL_DEFAULT;
            port_wake_out        <= `PORT_WAKE_DEFAULT;
            watchdog_control_out <= `WDOG_CTRL_DEFAULT; // RQ12
            pin_reset_select_out <= `PIN_SEL_DEFAULT;
            pin_sel              <= `PIN_SEL_DEFAULT;
          end
        end else begin
          delay <= delay + 16'h0001;
        end
      end
    end
  end
endmodule // reset_state_controller

// File: rtl/reset_state_map.vh
`ifndef RESET_STATE_MAP_VH
`define RESET_STATE_MAP_VH
// ****************************************************************
// Reset values and timing
// ****************************************************************
`define WDOG_CTRL_DEFAULT     8'h53
`define PIN_SEL_DEFAULT       8'h55
`define PIN_SEL_GPIO          8'h55
`define PIN_SEL_RESET         8'haa
`define INTC_DEFAULT          8'h00
`define TIMER_CTRL_DEFAULT    8'h00
`define PORT_DIR_DEFAULT      8'hff
`define PORT_DATA_DEFAULT     8'hff
`define PORT_PULL_DEFAULT     8'h00
`define PORT_WAKE_DEFAULT     8'h00
`define PC_RESET              12'h000
`define PCL_RESET             8'h00
`define SP_TOP                4'h0
`define STARTUP_CYCLES        16
`define DEBOUNCE_SLOW_CLOCKS  3
`define CAUSE_POR             3'h0
`define CAUSE_LVR             3'h1
`define CAUSE_WDT_RUN         3'h2
`define CAUSE_WDT_HALT        3'h3
`define CAUSE_PIN_RUN         3'h4
`define CAUSE_PIN_HALT        3'h5
`define CAUSE_SEL             3'h6
`endif

// File: rtl/slow_debounce.v
`timescale 1ns/100ps
`include "reset_state_map.vh"
// ****************************************************************
// Counts slow oscillator ticks while a condition persists.
// ****************************************************************
module slow_debounce #(
  parameter TICKS = `DEBOUNCE_SLOW_CLOCKS
) (
  // Clock and reset
  input  wire core_clk_in,
  input  wire rst_in,
  // Condition
  input  wire slow_tick_in,
  input  wire cond_in,
  output reg  fire_out
);
  reg [3:0] count;
  always @(posedge core_clk_in) begin
    if (rst_in || !cond_in) begin
      count    <= 4'h0;
      fire_out <= 1'b0;
    end else if (slow_tick_in) begin
      if (count == TICKS[3:0] - 4'h1) begin
        fire_out <= 1'b1;
      end else begin
        count <= count + 4'h1;
      end
    end
  end
endmodule // slow_debounce

// File: tb/reset_state_chk.sv
`timescale 1ns/100ps
// ****
// Checks on every release of the core from reset, and the hold while power-on is asserted.
// ****
module reset_state_chk (
  input wire        core_clk_in, rst_in, power_on_in,
  input wire        core_reset_out, warm_out, cold_load_out, por_load_out,
  input wire        wdt_expiry_flag_out, powerdown_flag_out,
  input wire        watchdog_timer_clear_out,
  input wire [11:0] pc_out,
  input wire [3:0]  sp_out,
  input wire [7:0]  intc_out, port_a_direction_out, watchdog_control_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rel; $fell(core_reset_out); endsequence
  property p_hold; power_on_in |=> core_reset_out; endproperty
  property p_zero; s_rel |-> pc_out == 12'h000 && sp_out == 4'h0; endproperty
  property p_clr;
    s_rel |-> watchdog_timer_clear_out ##1 !watchdog_timer_clear_out;
  endproperty
  property p_warm;
    s_rel ##0 warm_out |-> wdt_expiry_flag_out && powerdown_flag_out;
  endproperty
  property p_por;
    s_rel ##0 por_load_out |-> !wdt_expiry_flag_out && !powerdown_flag_out;
  endproperty
  property p_keep; s_rel ##0 warm_out |-> intc_out == $past(intc_out);
  endproperty
  property p_port; s_rel ##0 cold_load_out |-> port_a_direction_out == 8'hff;
  endproperty
  property p_wdc; s_rel ##0 cold_load_out |-> watchdog_control_out == 8'h53;
  endproperty
  a_hold: assert property (p_hold) else $error("core not held");
  a_zero: assert property (p_zero) else $error("pc or sp not zero");
  a_clr: assert property (p_clr) else $error("no clear pulse");
  a_warm: assert property (p_warm) else $error("warm flags");
  a_por: assert property (p_por) else $error("power-on flags");
  a_keep: assert property (p_keep) else $error("warm lost intc");
  a_port: assert property (p_port) else $error("port not input");
  a_wdc: assert property (p_wdc) else $error("watchdog default");
  c_warm: cover property (s_rel ##0 warm_out);
  c_por: cover property (s_rel ##0 por_load_out);
  c_cold: cover property (s_rel ##0 cold_load_out && !por_load_out);
endmodule // reset_state_chk
bind reset_state_controller reset_state_chk u_chk (.core_clk_in, .rst_in,
  .power_on_in, .core_reset_out, .warm_out, .cold_load_out, .por_load_out,
  .wdt_expiry_flag_out, .powerdown_flag_out, .watchdog_timer_clear_out,
  .pc_out, .sp_out, .intc_out, .port_a_direction_out, .watchdog_control_out);

// File: tb/reset_far_side.sv
`timescale 1ns/100ps
// ****
// Reset pin source and slow oscillator.
// ****
module reset_far_side (
  input  wire core_clk_in,
  input  wire pin_go_in,
  output reg  ext_reset_pin_n_out,
  output reg  slow_tick_out
);
  reg [2:0] cnt = 3'h0;
  reg [2:0] low_left = 3'h0;
  initial ext_reset_pin_n_out = 1'b1;
  initial slow_tick_out = 1'b0;
  always @(posedge core_clk_in) begin
    cnt <= cnt + 3'h1;
    slow_tick_out <= (cnt == 3'h7);
    if (pin_go_in) low_left <= 3'h5;
    else if (low_left != 3'h0) low_left <= low_left - 3'h1;
    // Pull-up takes the pin high once the pulse ends.
    ext_reset_pin_n_out <= !(pin_go_in || low_left > 3'h1);
  end
endmodule // reset_far_side

// File: tb/tb_top.sv
`timescale 1ns/100ps
`define check_eq(g, e) begin checks_done = checks_done + 1; \
  if ((g) !== (e)) begin num_errors = num_errors + 1; \
  $display("wrong value at %0t got %h expected %h", $time, g, e); end end
module tb_top;
  reg core_clk_in = 1'b0, rst_in = 1'b1, power_on_in = 1'b0, pin_go = 1'b0;
  reg supply_drop_reset_in = 1'b0, watchdog_expire_in = 1'b0;
  reg halted_in = 1'b0, pin_sel_wr_in = 1'b0, sd_flag_clr_in = 1'b0;
  reg  [7:0]  pin_sel_data_in = 8'h55;
  wire ext_reset_pin_n_in, slow_tick_in, core_reset_out, warm_out;
  wire cold_load_out, por_load_out, wdt_expiry_flag_out, powerdown_flag_out;
  wire supply_drop_cause_flag_out, watchdog_timer_clear_out;
  wire [11:0] pc_out;
  wire [3:0]  sp_out;
  wire [7:0]  pcl_out, intc_out, timer_ctrl_out, port_a_direction_out;
  wire [7:0]  port_data_out, port_pull_out, port_wake_out;
  wire [7:0]  watchdog_control_out, pin_reset_select_out;
  integer num_errors = 0, checks_done = 0, i;
  always #5 core_clk_in = ~core_clk_in;
  reset_state_controller #(.STARTUP(4)) u_dut (.core_clk_in, .rst_in,
    .power_on_in, .supply_drop_reset_in, .ext_reset_pin_n_in,
    .watchdog_expire_in, .halted_in, .slow_tick_in, .pin_sel_wr_in,
    .pin_sel_data_in, .sd_flag_clr_in, .core_reset_out, .warm_out,
    .cold_load_out, .por_load_out, .wdt_expiry_flag_out, .powerdown_flag_out,
    .supply_drop_cause_flag_out, .watchdog_timer_clear_out, .pc_out, .pcl_out,
    .sp_out, .intc_out, .timer_ctrl_out, .port_a_direction_out, .port_data_out,
    .port_pull_out, .port_wake_out, .watchdog_control_out,
    .pin_reset_select_out);
  reset_far_side u_far (.core_clk_in, .pin_go_in(pin_go),
    .ext_reset_pin_n_out(ext_reset_pin_n_in), .slow_tick_out(slow_tick_in));
  task tally_and_finish; begin
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  end endtask
  // Bounded so a core stuck in reset ends the run.
  task wait_release; begin
    i = 0;
    while (core_reset_out !== 1'b1 && i < 200) begin
      @(posedge core_clk_in); #1; i = i + 1;
    end
    while (core_reset_out !== 1'b0 && i < 200) begin
      @(posedge core_clk_in); #1; i = i + 1;
    end
    if (i == 200) begin num_errors = num_errors + 1; tally_and_finish; end
  end endtask
  task pulse(input [3:0] s, input h); begin
    @(posedge core_clk_in);
    {power_on_in, supply_drop_reset_in, watchdog_expire_in, pin_go} <= s;
    halted_in <= h;
    @(posedge core_clk_in);
    {power_on_in, supply_drop_reset_in, watchdog_expire_in, pin_go} <= 4'h0;
    wait_release;
  end endtask
  task sel(input [7:0] v); begin
    @(posedge core_clk_in);
    pin_sel_wr_in <= 1'b1;
    pin_sel_data_in <= v;
    @(posedge core_clk_in);
    pin_sel_wr_in <= 1'b0;
  end endtask
  task flags(input [1:0] e); begin
    `check_eq({wdt_expiry_flag_out, powerdown_flag_out}, e)
  end endtask
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    wait_release;
    flags(2'b00);
    `check_eq({port_a_direction_out, port_data_out}, 16'hffff)
    `check_eq({port_pull_out, port_wake_out}, 16'h0000)
    `check_eq({timer_ctrl_out, intc_out}, 16'h0000)
    `check_eq({watchdog_control_out, pin_reset_select_out}, 16'h5355)
    `check_eq({pc_out, pcl_out, sp_out}, 24'h000000)
    pulse(4'h2, 1'b0);
    flags(2'b10);
    sel(8'haa);
    pulse(4'h2, 1'b1);
    flags(2'b11);
    `check_eq({warm_out, pc_out}, 13'h1000)
    `check_eq(pin_reset_select_out, 8'haa)
    sel(8'haa);
    pulse(4'h1, 1'b1);
    flags(2'b01);
    `check_eq(pin_reset_select_out, 8'h55)
    sel(8'haa);
    pulse(4'h1, 1'b0);
    flags(2'b01);
    pulse(4'h4, 1'b0);
    flags(2'b01);
    `check_eq(supply_drop_cause_flag_out, 1'b1)
    @(posedge core_clk_in);
    sd_flag_clr_in <= 1'b1;
    @(posedge core_clk_in);
    sd_flag_clr_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    `check_eq(supply_drop_cause_flag_out, 1'b0)
    sel(8'h12);
    wait_release;
    `check_eq(pin_reset_select_out, 8'h55)
    pulse(4'ha, 1'b0);
    flags(2'b00);
    tally_and_finish;
  end
endmodule // tb_top
